// File: logic/wol_detector.sv
// wake-on-lan detector: remote-wake pattern, wake-up frames, link change
`timescale 1ns/1ps
module wol_detector
  import wol_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // receive byte stream from the mac
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic rx_crc_ok,
  input wire logic rx_addr_hit,
  // configuration
  input wire logic [47:0] station_addr,
  input wire logic [7:0] wake_frame_control,
  input wire logic [MASK_BYTES-1:0] wake_byte_mask [NUM_WAKE_FRAMES],
  input wire logic [15:0] wake_crc [NUM_WAKE_FRAMES],
  input wire logic link_wake_en,
  input wire logic link_up,
  input wire logic pme_clear,
  // wake indications
  output logic power_event_out_n,
  output logic [2:0] wake_source,
  output logic [NUM_WAKE_FRAMES-1:0] wake_frame_hit
);

  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc;
    for (int k = 7; k >= 0; k--) begin
      if (c[15] ^ b[k]) begin
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  //----------------------------------------------------------------------
  // remote-wake pattern scanner
  //----------------------------------------------------------------------
  wol_scan_type scan_r, scan_nxt, scan_b;
  logic [2:0] sync_r, sync_nxt, sync_b;
  logic [2:0] idx_r, idx_nxt;
  logic [3:0] copy_r, copy_nxt;
  logic [7:0] exp_byte;

  always_comb begin
    scan_b = rx_sof ? SCAN_HUNT : scan_r;
    sync_b = rx_sof ? 3'h0 : sync_r;
    scan_nxt = scan_b;
    sync_nxt = sync_b;
    idx_nxt = rx_sof ? 3'h0 : idx_r;
    copy_nxt = rx_sof ? 4'h0 : copy_r;
    exp_byte = station_addr[47 - 8*idx_r -: 8];
    if (!wake_frame_control[WFC_REMOTE_EN_BIT]) begin
      scan_nxt = SCAN_HUNT;
      sync_nxt = 3'h0;
      idx_nxt = 3'h0;
      copy_nxt = 4'h0;
    end else if (rx_valid) begin
      unique case (scan_b)
        SCAN_HUNT: begin
          if (rx_data == SYNC_BYTE) begin
            // a longer ff run still leaves the last six as sync
            sync_nxt = (sync_b == 3'(SYNC_LEN)) ? sync_b : 3'(sync_b + 3'h1);
          end else if (sync_b == 3'(SYNC_LEN) && rx_data == station_addr[47:40]) begin
            scan_nxt = SCAN_ADDR;
            idx_nxt = 3'h1;
            copy_nxt = 4'h0;
          end else begin
            sync_nxt = 3'h0;
          end
        end
        SCAN_ADDR: begin
          if (rx_data == exp_byte) begin
            if (idx_r == 3'(ADDR_BYTES - 1)) begin
              idx_nxt = 3'h0;
              if (copy_r == 4'(ADDR_COPIES - 1)) begin
                scan_nxt = SCAN_FOUND;
              end else begin
                copy_nxt = 4'(copy_r + 4'h1);
              end
            end else begin
              idx_nxt = 3'(idx_r + 3'h1);
            end
          end else begin
            // breaking byte may itself open a new sync run
            scan_nxt = SCAN_HUNT;
            idx_nxt = 3'h0;
            copy_nxt = 4'h0;
            sync_nxt = (rx_data == SYNC_BYTE) ? 3'h1 : 3'h0;
          end
        end
        SCAN_FOUND: begin
          scan_nxt = SCAN_FOUND;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      scan_r <= SCAN_HUNT;
      sync_r <= 3'h0;
      idx_r <= 3'h0;
      copy_r <= 4'h0;
    end else begin
      scan_r <= scan_nxt;
      sync_r <= sync_nxt;
      idx_r <= idx_nxt;
      copy_r <= copy_nxt;
    end
  end

  //----------------------------------------------------------------------
  // wake-up frame checksums over masked bytes
  //----------------------------------------------------------------------
  logic [6:0] pos_r, pos_nxt, pos_b;
  logic [15:0] crc_r [NUM_WAKE_FRAMES];
  logic [15:0] crc_nxt [NUM_WAKE_FRAMES];

  always_comb begin
    pos_b = rx_sof ? 7'h00 : pos_r;
    pos_nxt = pos_b;
    // bytes past the mask window never enter the checksum
    if (rx_valid && pos_b < 7'(MASK_BYTES)) begin
      pos_nxt = 7'(pos_b + 7'h01);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WAKE_FRAMES; gi++) begin : g_frame
      logic [15:0] crc_b;
      always_comb begin
        crc_b = rx_sof ? CRC_INIT : crc_r[gi];
        crc_nxt[gi] = crc_b;
        if (rx_valid && pos_b < 7'(MASK_BYTES) && wake_byte_mask[gi][pos_b[5:0]]) begin
          crc_nxt[gi] = crc16_byte(crc_b, rx_data);
        end
      end
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          crc_r[gi] <= CRC_INIT;
        end else begin
          crc_r[gi] <= crc_nxt[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pos_r <= 7'h00;
    end else begin
      pos_r <= pos_nxt;
    end
  end

  //----------------------------------------------------------------------
  // frame end qualification and link change
  //----------------------------------------------------------------------
  logic frame_good;
  logic remote_hit;
  logic [NUM_WAKE_FRAMES-1:0] frame_hit;
  logic link_prev_r, link_prev_nxt;
  logic link_seen_r, link_seen_nxt;
  logic link_event;

  always_comb begin
    frame_good = rx_eof && rx_crc_ok && rx_addr_hit;
    // incomplete scan leaves scan_r short of found: no wake
    remote_hit = frame_good && wake_frame_control[WFC_REMOTE_EN_BIT] && scan_r == SCAN_FOUND;
    for (int i = 0; i < NUM_WAKE_FRAMES; i++) begin
      frame_hit[i] = frame_good && wake_frame_control[WFC_FRAME_EN_LSB + i] && crc_r[i] == wake_crc[i];
    end
    link_prev_nxt = link_up;
    link_seen_nxt = 1'b1;
    // first cycle after reset only learns the level
    link_event = link_seen_r && link_wake_en && (link_up != link_prev_r);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      link_prev_r <= 1'b0;
      link_seen_r <= 1'b0;
    end else begin
      link_prev_r <= link_prev_nxt;
      link_seen_r <= link_seen_nxt;
    end
  end

  //----------------------------------------------------------------------
  // sticky wake status and power event output
  //----------------------------------------------------------------------
  logic [2:0] src_r, src_nxt;
  logic [NUM_WAKE_FRAMES-1:0] hit_r, hit_nxt;
  logic pme_n_r, pme_n_nxt;
  logic [2:0] src_set;

  always_comb begin
    src_set = 3'h0;
    src_set[SRC_LINK_BIT] = link_event;
    src_set[SRC_FRAME_BIT] = |frame_hit;
    src_set[SRC_REMOTE_BIT] = remote_hit;
    // set wins over a clear in the same cycle
    src_nxt = (pme_clear ? 3'h0 : src_r) | src_set;
    hit_nxt = (pme_clear ? {NUM_WAKE_FRAMES{1'b0}} : hit_r) | frame_hit;
    pme_n_nxt = ~|src_nxt;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      src_r <= 3'h0;
      hit_r <= {NUM_WAKE_FRAMES{1'b0}};
      pme_n_r <= 1'b1;
    end else begin
      src_r <= src_nxt;
      hit_r <= hit_nxt;
      pme_n_r <= pme_n_nxt;
    end
  end

  assign power_event_out_n = pme_n_r;
  assign wake_source = src_r;
  assign wake_frame_hit = hit_r;

endmodule

// File: logic/wol_pkg.sv
// constants and notes for the wake-on-lan detector
//----------------------------------------------------------------------
// Notes on behaviour
// - Four wake-up frame patterns exist, each with its own bank of settings, enabled by control bits 0 to 3.
// - A wake-up frame is recognised when the checksum over its selected bytes equals the stored checksum.
// - Frames addressed to the node are scanned for the remote-wake pattern only while control bit 7 is one.
// - The remote-wake pattern is sixteen back-to-back copies of the six-byte station address.
// - The sixteen copies must directly follow a run of six bytes of value ff.
// - The sync run and copies may start at any byte position of the frame.
// - A remote-wake frame counts only if it is well formed with good checksum and addressed to us.
// - A broadcast frame qualifies as long as its sixteen copies equal our own station address.
// - No protocol restriction applies; the pattern may sit inside any payload.
// - A frame without the complete pattern gives no remote-wake indication.
// - On a complete pattern the power event output is asserted.
// - Each link transition, up or down, raises a link wake event.
// - A wake signal comes from a link change, an enabled wake-up frame or a remote-wake frame.
//----------------------------------------------------------------------
package wol_pkg;

  //----------------------------------------------------------------------
  // pattern scan
  //----------------------------------------------------------------------
  localparam int SYNC_LEN = 6;
  localparam logic [7:0] SYNC_BYTE = 8'hff;
  localparam int ADDR_BYTES = 6;
  localparam int ADDR_COPIES = 16;

  //----------------------------------------------------------------------
  // wake-up frames, one bank each starting at bank 4
  //----------------------------------------------------------------------
  localparam int NUM_WAKE_FRAMES = 4;
  localparam int MASK_BYTES = 64;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  //----------------------------------------------------------------------
  // wake frame control bits and status bits
  //----------------------------------------------------------------------
  localparam int WFC_FRAME_EN_LSB = 0;
  localparam int WFC_REMOTE_EN_BIT = 7;
  localparam int SRC_LINK_BIT = 0;
  localparam int SRC_FRAME_BIT = 1;
  localparam int SRC_REMOTE_BIT = 2;

  typedef enum logic [1:0] {SCAN_HUNT, SCAN_ADDR, SCAN_FOUND} wol_scan_type;

endpackage

// File: test/test_wol_detector.sv
// self-checking bench for the wake-on-lan detector
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module test_wol_detector
  import wol_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic rx_valid, rx_sof, rx_eof, rx_crc_ok, rx_addr_hit;
  logic [7:0] rx_data;
  logic [47:0] station_addr = 48'h02a1b2c3d4e5;
  logic [7:0] wake_frame_control = 8'h00;
  logic [MASK_BYTES-1:0] wake_byte_mask [NUM_WAKE_FRAMES];
  logic [15:0] wake_crc [NUM_WAKE_FRAMES];
  logic link_wake_en = 1'b1;
  logic link_up = 1'b1;
  logic pme_clear = 1'b0;
  logic power_event_out_n;
  logic [2:0] wake_source;
  logic [NUM_WAKE_FRAMES-1:0] wake_frame_hit;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  wol_detector dut_u (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_sof(rx_sof),
    .rx_eof(rx_eof),
    .rx_crc_ok(rx_crc_ok),
    .rx_addr_hit(rx_addr_hit),
    .station_addr(station_addr),
    .wake_frame_control(wake_frame_control),
    .wake_byte_mask(wake_byte_mask),
    .wake_crc(wake_crc),
    .link_wake_en(link_wake_en),
    .link_up(link_up),
    .pme_clear(pme_clear),
    .power_event_out_n(power_event_out_n),
    .wake_source(wake_source),
    .wake_frame_hit(wake_frame_hit)
  );
  wol_mac_model mac_u (
    .mclk(mclk),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_sof(rx_sof),
    .rx_eof(rx_eof),
    .rx_crc_ok(rx_crc_ok),
    .rx_addr_hit(rx_addr_hit)
  );
  // ------------
  // helpers
  // ------------
  function automatic logic [15:0] crc16(input logic [47:0] d);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 47; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic push_addr(input int n);
    repeat (n) for (int b = 5; b >= 0; b--) mac_u.q.push_back(station_addr[b*8 +: 8]);
  endtask
  task automatic fin(input logic [2:0] es, input logic [3:0] eh);
    repeat (3) @(posedge mclk);
    #1;
    `CHK("wake_source", es, wake_source)
    `CHK("wake_frame_hit", eh, wake_frame_hit)
    `CHK("power_event_out_n", es == 3'h0, power_event_out_n)
    @(posedge mclk);
    pme_clear <= 1'b1;
    @(posedge mclk);
    pme_clear <= 1'b0;
    $display("test done, source %h", es);
  endtask
  // every pattern crc matches the frame head, so only the enables decide hits
  task automatic rw(input logic en, ok, pre, input int n, input logic [2:0] es);
    wake_frame_control <= {en, 7'h00};
    push_addr(1);
    mac_u.q.push_back(8'h00);
    mac_u.q.push_back(8'h12);
    if (pre) begin
      repeat (6) mac_u.q.push_back(SYNC_BYTE);
      push_addr(3);
    end
    repeat (7) mac_u.q.push_back(SYNC_BYTE);
    push_addr(n);
    mac_u.q.push_back(8'h00);
    mac_u.q.push_back(8'h34);
    mac_u.send(ok);
    fin(es, 4'h0);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ------------
  // sequence
  // ------------
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    for (int i = 0; i < NUM_WAKE_FRAMES; i++) begin
      wake_byte_mask[i] = 64'h3f;
      wake_crc[i] = crc16(station_addr);
    end
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rw(1'b1, 1'b1, 1'b0, 16, 3'h4);
    rw(1'b1, 1'b1, 1'b0, 15, 3'h0);
    rw(1'b0, 1'b1, 1'b0, 16, 3'h0);
    rw(1'b1, 1'b0, 1'b0, 16, 3'h0);
    rw(1'b1, 1'b1, 1'b1, 16, 3'h4);
    // third toggle runs with link events masked
    for (int k = 0; k < 3; k++) begin
      link_wake_en <= (k != 2);
      @(posedge mclk);
      link_up <= ~link_up;
      fin((k != 2) ? 3'h1 : 3'h0, 4'h0);
    end
    link_wake_en <= 1'b1;
    // last pass spoils one stored checksum: no hit wanted
    for (int i = 0; i <= NUM_WAKE_FRAMES; i++) begin
      @(posedge mclk);
      if (i == NUM_WAKE_FRAMES) begin
        wake_crc[0] <= ~wake_crc[0];
      end
      wake_frame_control <= 8'h01 << (i % NUM_WAKE_FRAMES);
      push_addr(1);
      repeat (10) mac_u.q.push_back(8'h00);
      mac_u.send(1'b1);
      fin((i < NUM_WAKE_FRAMES) ? 3'h2 : 3'h0, (i < NUM_WAKE_FRAMES) ? 4'h1 << i : 4'h0);
    end
    summarize();
  end
endmodule

// File: test/wol_detector_props.sv
// assertions on the wake-on-lan detector ports
`timescale 1ns/1ps
module wol_detector_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // stream end and configuration
  input wire logic rx_eof,
  input wire logic rx_crc_ok,
  input wire logic rx_addr_hit,
  input wire logic [7:0] wake_frame_control,
  input wire logic link_wake_en,
  input wire logic link_up,
  input wire logic pme_clear,
  // wake indications
  input wire logic power_event_out_n,
  input wire logic [2:0] wake_source,
  input wire logic [3:0] wake_frame_hit
);
  // ------------
  // properties
  // ------------
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire good_eof = rx_eof & rx_crc_ok & rx_addr_hit;
  wire remote_eof = good_eof & wake_frame_control[7];
  a_pme_follows_src: assert property (power_event_out_n == ~|wake_source)
    else $error("power event out of step with wake source");
  // skip the first edge after reset, where the link level is only recorded
  a_link_event: assert property (link_wake_en && $changed(link_up) && !$past(sys_rst) |=> wake_source[0])
    else $error("link change gave no event");
  a_link_cause: assert property ($rose(wake_source[0]) |-> $past(link_wake_en) && $past(link_up) != $past(link_up, 2))
    else $error("link event without link change");
  a_remote_cause: assert property ($rose(wake_source[2]) |-> $past(remote_eof) || $past(remote_eof, 2))
    else $error("remote wake without good enabled frame end");
  a_frame_cause: assert property ($rose(wake_source[1]) |-> ($past(good_eof) || $past(good_eof, 2)) && |wake_frame_hit)
    else $error("wake frame event without good frame end");
  a_hit_enabled: assert property ((wake_frame_hit & ~$past(wake_frame_hit) & ~$past(wake_frame_control[3:0])) == 4'h0)
    else $error("disabled wake pattern reported a hit");
  a_clear_wins: assert property (pme_clear && !rx_eof && !$past(rx_eof) && $stable(link_up) && $past(link_up) == $past(link_up, 2) |=> wake_source == 3'h0)
    else $error("clear left status set");
  a_sticky_hold: assert property (!pme_clear |=> (wake_source & $past(wake_source)) == $past(wake_source))
    else $error("status dropped without clear");
  cover property ($rose(wake_source[2]));
  cover property ($rose(wake_source[0]));
  cover property ($rose(|wake_frame_hit));
endmodule
bind wol_detector wol_detector_chk chk_u (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .rx_eof(rx_eof),
  .rx_crc_ok(rx_crc_ok),
  .rx_addr_hit(rx_addr_hit),
  .wake_frame_control(wake_frame_control),
  .link_wake_en(link_wake_en),
  .link_up(link_up),
  .pme_clear(pme_clear),
  .power_event_out_n(power_event_out_n),
  .wake_source(wake_source),
  .wake_frame_hit(wake_frame_hit)
);

// File: test/wol_mac_model.sv
// receive mac stand-in that plays queued frames into the detector
`timescale 1ns/1ps
module wol_mac_model (
  // clock
  input wire logic mclk,
  // receive stream
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_sof,
  output logic rx_eof,
  output logic rx_crc_ok,
  output logic rx_addr_hit
);
  logic [7:0] q [$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h5a;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_crc_ok = 1'b0;
    rx_addr_hit = 1'b0;
  end
  task automatic send(input logic ok);
    foreach (q[i]) begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_data <= q[i];
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_sof <= 1'b0;
    // idle data is scrambled so a stale byte never looks valid
    rx_data <= ~q[q.size()-1];
    rx_eof <= 1'b1;
    rx_crc_ok <= ok;
    rx_addr_hit <= 1'b1;
    @(posedge mclk);
    rx_eof <= 1'b0;
    rx_crc_ok <= 1'b0;
    rx_addr_hit <= 1'b0;
    q = {};
  endtask
endmodule
